// >>> logic/ctta_core.sv
`default_nettype none
module ctta_core (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        cache_test_mode,
  input  wire logic        tlb_test_mode,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic [8:0]  acc_addr,
  input  wire logic [31:0] acc_wdata,
  output logic      [31:0] rd_data,
  output logic             rd_valid
);
  import ctta_pkg::*;

  function automatic logic [1:0] ctta_perm_decode(input logic [3:0] onehot);
    logic [1:0] code;
    code = 2'h0;
    unique case (onehot)
      4'h2: code = 2'h1;
      4'h4: code = 2'h2;
      4'h8: code = 2'h3;
      default: code = 2'h0;
    endcase
    return code;
  endfunction

  function automatic logic [1:0] ctta_domain_field(input logic [15:0] dom,
                                                   input logic [31:0] dac);
    logic [1:0] f;
    f = 2'h0;
    for (int d = 0; d < 16; d++) begin
      if (dom[d]) begin
        f = dac[2*d +: 2];
      end
    end
    return f;
  endfunction

  function automatic logic [3:0] ctta_size_fix(input logic [3:0] code,
                                               input logic       second);
    logic [3:0] fallback;
    fallback = second ? SEC_SIZE_1K : TAG_SIZE_1K;
    if (code == TAG_SIZE_1M || code == TAG_SIZE_64K || code == TAG_SIZE_16K ||
        code == TAG_SIZE_4K || code == TAG_SIZE_1K) begin
      return code;
    end
    return fallback;
  endfunction

  // Burst offset bits above the location are only a length hint
  logic [5:0] loc;
  assign loc = acc_addr[BURST_SHIFT-1:0];

  logic c_acc;
  logic t_acc;
  assign c_acc = acc_req & cache_test_mode;
  assign t_acc = acc_req & tlb_test_mode & ~cache_test_mode;

  logic c_tag_acc, c_data_acc, c_match_wr, c_match_rd, c_inv_all, c_dirty_all;
  logic c_ptr_wr, c_inv_va;
  assign c_tag_acc = c_acc & (loc == LOC_C_TAG);
  assign c_data_acc = c_acc & (loc == LOC_C_DATA);
  assign c_match_wr = c_acc & acc_write & (loc == LOC_C_MATCH);
  assign c_match_rd = c_acc & ~acc_write & (loc == LOC_C_MATCH);
  assign c_inv_all = c_acc & acc_write & (loc == LOC_C_INV_ALL);
  assign c_dirty_all = c_acc & acc_write & (loc == LOC_C_DIRTY_ALL);
  assign c_ptr_wr = c_acc & acc_write & (loc == LOC_C_POINTER);
  assign c_inv_va = c_acc & acc_write & (loc == LOC_C_INV_VA);

  logic t_inv_va, t_match_wr, t_match_rd, t_tag_acc, t_first_acc, t_second_acc;
  logic t_comb_acc, t_dom_acc, t_lock_acc, t_inv_all;
  assign t_inv_va = t_acc & acc_write & (loc == LOC_T_INV_VA);
  assign t_match_wr = t_acc & acc_write & (loc == LOC_T_MATCH);
  assign t_match_rd = t_acc & ~acc_write & (loc == LOC_T_MATCH);
  assign t_tag_acc = t_acc & (loc == LOC_T_TAG);
  assign t_first_acc = t_acc & (loc == LOC_T_FIRST);
  assign t_second_acc = t_acc & (loc == LOC_T_SECOND);
  assign t_comb_acc = t_acc & (loc == LOC_T_COMBINED);
  assign t_dom_acc = t_acc & (loc == LOC_T_DOMAIN);
  assign t_lock_acc = t_acc & (loc == LOC_T_LOCK);
  assign t_inv_all = t_acc & acc_write & (loc == LOC_T_INV_ALL);

  // Cache state
  logic [7:0]   c_seg_idx;
  logic [5:0]   c_idx_reg;
  logic [1:0]   c_seg_reg;
  logic [2:0]   c_word_reg;
  logic [6:0]   replacement_shift_register_reg;
  logic [255:0] c_valid_reg;
  logic [255:0] c_deven_reg;
  logic [255:0] c_dodd_reg;
  logic [27:0]  c_tag_mem [0:255];
  logic [31:0]  c_data_mem [0:2047];
  logic         c_hit_reg;
  logic [10:0]  c_match_addr_reg;
  assign c_seg_idx = {c_seg_reg, c_idx_reg};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      c_idx_reg <= 6'h00;
      c_seg_reg <= 2'h0;
      c_word_reg <= 3'h0;
    end else if (c_ptr_wr) begin
      c_idx_reg <= acc_wdata[C_PTR_IDX_LSB +: 6];
      c_seg_reg <= acc_wdata[C_SEG_LSB +: 2];
      c_word_reg <= acc_wdata[C_PTR_WORD_LSB +: 3];
    end else if (c_tag_acc || c_data_acc) begin
      c_idx_reg <= c_idx_reg + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      replacement_shift_register_reg <= REPLACEMENT_SHIFT_REGISTER_RESET;
    end else begin
      replacement_shift_register_reg <= {replacement_shift_register_reg[5:0], replacement_shift_register_reg[6] ^ replacement_shift_register_reg[5]};
    end
  end

  // Per-entry comparators shared by match and invalidate
  logic [255:0] c_tag_eq;
  logic [63:0]  t_tag_eq;
  genvar k;
  generate
    for (k = 0; k < 256; k++) begin : g_ceq
      assign c_tag_eq[k] = c_valid_reg[k] &&
                           (k / 64 == 32'(acc_wdata[C_SEG_LSB +: 2])) &&
                           (c_tag_mem[k][27:3] == acc_wdata[31:C_TAG_LSB]);
    end
  endgenerate

  logic       c_hit;
  logic [5:0] c_hit_idx;
  always_comb begin
    c_hit = 1'b0;
    c_hit_idx = 6'h00;
    for (int i = 0; i < 256; i++) begin
      if (c_tag_eq[i]) begin
        c_hit = 1'b1;
        c_hit_idx = 6'(i);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      c_valid_reg <= '0;
      c_deven_reg <= '0;
      c_dodd_reg <= '0;
    end else if (c_inv_all) begin
      c_valid_reg <= '0;
    end else if (c_dirty_all) begin
      c_deven_reg <= '1;
      c_dodd_reg <= '1;
    end else if (c_inv_va) begin
      c_valid_reg <= c_valid_reg & ~c_tag_eq;
    end else if (c_tag_acc && acc_write) begin
      c_valid_reg[c_seg_idx] <= acc_wdata[C_VALID_BIT];
      c_deven_reg[c_seg_idx] <= acc_wdata[C_DEVEN_BIT];
      c_dodd_reg[c_seg_idx] <= acc_wdata[C_DODD_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (c_tag_acc && acc_write) begin
      c_tag_mem[c_seg_idx] <= {acc_wdata[31:C_SEG_LSB], acc_wdata[C_WB_BIT]};
    end
    if (c_data_acc && acc_write) begin
      c_data_mem[{c_seg_idx, c_word_reg}] <= acc_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      c_hit_reg <= 1'b0;
      c_match_addr_reg <= 11'h000;
    end else if (c_match_wr) begin
      c_hit_reg <= c_hit;
      c_match_addr_reg <= {acc_wdata[C_SEG_LSB +: 2], c_hit_idx,
                           acc_wdata[C_PTR_WORD_LSB +: 3]};
    end
  end

  // Translation state
  logic [5:0]  t_idx_reg;
  logic [5:0]  t_lag_reg;
  logic        t_pair_reg;
  logic [31:0] t_dom_reg;
  logic [31:0] t_lock_reg;
  logic [63:0] t_valid_reg;
  logic [63:0] t_pres_reg;
  logic [25:0] t_tag_mem [0:63];
  logic [21:0] t_first_mem [0:63];
  logic [25:0] t_second_mem [0:63];
  logic [31:0] t_match_reg;
  logic        t_first_step;
  logic        t_second_step;
  assign t_first_step = t_tag_acc | t_first_acc | (t_comb_acc & ~t_pair_reg);
  assign t_second_step = t_second_acc | (t_comb_acc & t_pair_reg);

  generate
    for (k = 0; k < 64; k++) begin : g_teq
      assign t_tag_eq[k] = t_valid_reg[k] &&
                           (t_tag_mem[k][25:4] == acc_wdata[31:T_TAG_LSB]);
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      t_idx_reg <= 6'h00;
      t_lag_reg <= 6'h00;
      t_pair_reg <= 1'b0;
    end else begin
      if (t_lock_acc && acc_write) begin
        t_idx_reg <= acc_wdata[C_PTR_IDX_LSB +: 6];
      end else if (t_first_step) begin
        t_idx_reg <= t_idx_reg + 6'h01;
        t_lag_reg <= t_idx_reg;
      end
      if (t_comb_acc) begin
        t_pair_reg <= ~t_pair_reg;
      end else if (t_acc) begin
        t_pair_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      t_dom_reg <= DOMAIN_RESET;
      t_lock_reg <= 32'h0000_0000;
      t_valid_reg <= '0;
      t_pres_reg <= '0;
    end else begin
      if (t_dom_acc && acc_write) begin
        t_dom_reg <= acc_wdata;
      end
      if (t_lock_acc && acc_write) begin
        t_lock_reg <= acc_wdata & T_LOCK_MASK;
      end
      if (t_inv_all) begin
        t_valid_reg <= '0;
      end else if (t_inv_va) begin
        t_valid_reg <= t_valid_reg & ~t_tag_eq;
      end else if (t_tag_acc && acc_write) begin
        t_valid_reg[t_idx_reg] <= acc_wdata[T_VALID_BIT];
        t_pres_reg[t_idx_reg] <= acc_wdata[T_PRES_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (t_tag_acc && acc_write) begin
      t_tag_mem[t_idx_reg] <= {acc_wdata[31:T_TAG_LSB],
                               ctta_size_fix(acc_wdata[T_SIZE_LSB +: 4], 1'b0)};
    end
    if ((t_first_acc || (t_comb_acc && !t_pair_reg)) && acc_write) begin
      t_first_mem[t_idx_reg] <= acc_wdata[21:0];
    end
    if (t_second_step && acc_write) begin
      t_second_mem[t_lag_reg] <= {acc_wdata[31:T_TAG_LSB],
                                  ctta_size_fix(acc_wdata[T_SIZE_LSB +: 4], 1'b1)};
    end
  end

  logic       t_hit;
  logic [5:0] t_hit_idx;
  logic [1:0] t_dfield;
  always_comb begin
    t_hit = 1'b0;
    t_hit_idx = 6'h00;
    for (int i = 0; i < 64; i++) begin
      if (t_tag_eq[i]) begin
        t_hit = 1'b1;
        t_hit_idx = 6'(i);
      end
    end
    t_dfield = ctta_domain_field(t_first_mem[t_hit_idx][21:T_DOM_LSB], t_dom_reg);
  end

  // Fault bits are only computed here; plain first-array reads show zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      t_match_reg <= 32'h0000_0000;
    end else if (t_match_wr) begin
      t_match_reg <= '0;
      t_match_reg[T_MISS_BIT] <= ~t_hit;
      if (t_hit) begin
        t_match_reg[21:0] <= t_first_mem[t_hit_idx];
        t_match_reg[T_DFAULT_BIT] <= (t_dfield == 2'h0);
        t_match_reg[T_PFAULT_BIT] <= (t_dfield == 2'h1) &&
            (ctta_perm_decode(t_first_mem[t_hit_idx][3:0]) == 2'h0);
      end
    end
  end

  // Read port; write-only and unmapped locations answer zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      rd_valid <= acc_req & ~acc_write;
      rd_data <= 32'h0000_0000;
      if (acc_req && !acc_write) begin
        if (c_tag_acc) begin
          rd_data <= {c_tag_mem[c_seg_idx][27:3], c_tag_mem[c_seg_idx][2], 1'b0,
                      c_valid_reg[c_seg_idx], c_deven_reg[c_seg_idx],
                      c_dodd_reg[c_seg_idx], c_tag_mem[c_seg_idx][0],
                      replacement_shift_register_reg[6]};
        end else if (c_data_acc) begin
          rd_data <= c_data_mem[{c_seg_idx, c_word_reg}];
        end else if (c_match_rd) begin
          rd_data <= {~c_hit_reg, c_hit_reg,
                      c_data_mem[c_match_addr_reg][29:0]};
        end else if (t_match_rd) begin
          rd_data <= t_match_reg;
        end else if (t_tag_acc) begin
          rd_data <= {t_tag_mem[t_idx_reg], t_valid_reg[t_idx_reg],
                      t_pres_reg[t_idx_reg], 4'h0};
        end else if (t_first_acc || (t_comb_acc && !t_pair_reg)) begin
          rd_data <= {10'h000, t_first_mem[t_idx_reg]};
        end else if (t_second_step) begin
          rd_data <= {t_second_mem[t_lag_reg], 6'h00};
        end else if (t_dom_acc) begin
          rd_data <= t_dom_reg;
        end else if (t_lock_acc) begin
          rd_data <= t_lock_reg;
        end
      end
    end
  end

  AST_RD_ANSWER: assert property (@(posedge sys_clk) disable iff (reset)
    (acc_req && !acc_write) |=> rd_valid ##1 !rd_valid || $past(acc_req))
    else $error("Read not answered next cycle");

  AST_C_IDX_INC: assert property (@(posedge sys_clk) disable iff (reset)
    (c_tag_acc || c_data_acc) |=> c_idx_reg == $past(c_idx_reg) + 6'h01
      && c_seg_reg == $past(c_seg_reg) && c_word_reg == $past(c_word_reg))
    else $error("Cache index did not step");

  AST_C_PTR_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
    c_ptr_wr |=> c_idx_reg == $past(acc_wdata[31:26]) && c_word_reg == $past(acc_wdata[4:2]))
    else $error("Pointer write not taken");

  AST_C_TAG_LOW: assert property (@(posedge sys_clk) disable iff (reset)
    (c_tag_acc && !acc_write) |=> rd_data[0] == $past(replacement_shift_register_reg[6]) && !rd_data[5])
    else $error("Tag read low bits wrong");

  AST_C_MATCH_FLAGS: assert property (@(posedge sys_clk) disable iff (reset)
    c_match_rd |=> rd_data[31] != rd_data[30])
    else $error("Hit and miss not exclusive");

  AST_T_LAG: assert property (@(posedge sys_clk) disable iff (reset)
    (t_first_step && !(t_lock_acc && acc_write)) |=> t_lag_reg == $past(t_idx_reg)
      && t_idx_reg == $past(t_idx_reg) + 6'h01)
    else $error("Second index does not lag");

  AST_T_FAULT_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    (t_first_acc && !acc_write) |=> rd_data[31:22] == 10'h000)
    else $error("Fault bits shown outside match");

  AST_T_DOMAIN_RW: assert property (@(posedge sys_clk) disable iff (reset)
    (t_dom_acc && acc_write) ##1 !acc_req ##1 (t_dom_acc && !acc_write)
      |=> rd_data == $past(acc_wdata, 3))
    else $error("Domain word not returned");

  AST_T_SECOND_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    t_second_acc |=> t_idx_reg == $past(t_idx_reg))
    else $error("Second array access moved index");
endmodule
`default_nettype wire

// >>> logic/ctta_pkg.sv
`default_nettype none
package ctta_pkg;
  localparam int unsigned BURST_SHIFT = 6;
  localparam logic [5:0] LOC_C_TAG = 6'h04;
  localparam logic [5:0] LOC_C_DATA = 6'h08;
  localparam logic [5:0] LOC_C_MATCH = 6'h0c;
  localparam logic [5:0] LOC_C_INV_ALL = 6'h10;
  localparam logic [5:0] LOC_C_DIRTY_ALL = 6'h14;
  localparam logic [5:0] LOC_C_POINTER = 6'h18;
  localparam logic [5:0] LOC_C_INV_VA = 6'h1c;
  localparam logic [5:0] LOC_T_INV_VA = 6'h04;
  localparam logic [5:0] LOC_T_MATCH = 6'h08;
  localparam logic [5:0] LOC_T_TAG = 6'h24;
  localparam logic [5:0] LOC_T_FIRST = 6'h28;
  localparam logic [5:0] LOC_T_SECOND = 6'h2c;
  localparam logic [5:0] LOC_T_COMBINED = 6'h30;
  localparam logic [5:0] LOC_T_DOMAIN = 6'h34;
  localparam logic [5:0] LOC_T_LOCK = 6'h38;
  localparam logic [5:0] LOC_T_INV_ALL = 6'h3c;
  localparam int unsigned C_TAG_LSB = 7;
  localparam int unsigned C_SEG_LSB = 5;
  localparam int unsigned C_VALID_BIT = 4;
  localparam int unsigned C_DEVEN_BIT = 3;
  localparam int unsigned C_DODD_BIT = 2;
  localparam int unsigned C_WB_BIT = 1;
  localparam int unsigned C_PTR_IDX_LSB = 26;
  localparam int unsigned C_PTR_WORD_LSB = 2;
  localparam int unsigned C_MISS_BIT = 31;
  localparam int unsigned C_HIT_BIT = 30;
  localparam int unsigned T_TAG_LSB = 10;
  localparam int unsigned T_SIZE_LSB = 6;
  localparam int unsigned T_VALID_BIT = 5;
  localparam int unsigned T_PRES_BIT = 4;
  localparam int unsigned T_PFAULT_BIT = 24;
  localparam int unsigned T_DFAULT_BIT = 23;
  localparam int unsigned T_MISS_BIT = 22;
  localparam int unsigned T_DOM_LSB = 6;
  localparam logic [31:0] T_LOCK_MASK = 32'hfff0_0001;
  localparam logic [3:0] TAG_SIZE_1M = 4'hf;
  localparam logic [3:0] TAG_SIZE_64K = 4'h7;
  localparam logic [3:0] TAG_SIZE_16K = 4'h3;
  localparam logic [3:0] TAG_SIZE_4K = 4'h1;
  localparam logic [3:0] TAG_SIZE_1K = 4'h0;
  localparam logic [3:0] SEC_SIZE_4K = 4'h0;
  localparam logic [3:0] SEC_SIZE_1K = 4'h1;
  localparam logic [6:0] REPLACEMENT_SHIFT_REGISTER_RESET = 7'h01;
  localparam logic [31:0] DOMAIN_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> testbench/ctta_tester.sv
`default_nettype none
// External test bus master that issues one access per task call
module ctta_tester (
  input  wire logic        sys_clk,
  output var  logic        acc_req,
  output var  logic        acc_write,
  output var  logic [8:0]  acc_addr,
  output var  logic [31:0] acc_wdata,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_addr = 9'h000;
    acc_wdata = 32'h0000_0000;
  end
  // One beat: raise after an edge, hold through the taking edge, then release
  task automatic xfer(input logic wr, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic v);
    @(posedge sys_clk);
    #2;
    acc_req = 1'b1;
    acc_write = wr;
    acc_addr = a;
    acc_wdata = d;
    @(posedge sys_clk);
    #2;
    acc_req = 1'b0;
    // Released data inverted so a stale sample never looks right
    acc_wdata = ~d;
    q = rd_data;
    v = rd_valid;
  endtask
endmodule
`default_nettype wire

// >>> testbench/cache_tlb_test_access_tb.sv
`default_nettype none
module cache_tlb_test_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ctta_pkg::*;
  logic        sys_clk;
  logic        reset;
  logic        cache_test_mode;
  logic        tlb_test_mode;
  logic        acc_req;
  logic        acc_write;
  logic [8:0]  acc_addr;
  logic [31:0] acc_wdata;
  logic [31:0] rd_data;
  logic        rd_valid;
  int          miscompares = 0;
  int          n_checks = 0;
  int          seed = 79;
  logic [31:0] q;
  logic        v;
  logic [31:0] d;
  logic [31:0] tt;
  logic [31:0] ts;
  logic [31:0] tf;
  logic [31:0] ctag [int];
  logic [31:0] cdat [int];
  logic [3:0]  tc [6] = '{4'h5, 4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
  logic [3:0]  sc [6] = '{4'h5, 4'hf, 4'h7, 4'h3, 4'h0, 4'h1};

  ctta_core i_dut (.sys_clk(sys_clk), .reset(reset), .cache_test_mode(cache_test_mode),
    .tlb_test_mode(tlb_test_mode), .acc_req(acc_req), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
  ctta_tester i_tester (.sys_clk(sys_clk), .acc_req(acc_req), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] b, input logic [5:0] l, input logic [31:0] wd);
    logic [31:0] x;
    logic        y;
    i_tester.xfer(1'b1, {b, l}, wd, x, y);
  endtask

  task automatic rdc(input logic [2:0] b, input logic [5:0] l, input logic [31:0] e,
                     input logic [31:0] m);
    i_tester.xfer(1'b0, {b, l}, 32'h0, q, v);
    chk({31'h0, v}, 32'h1, 32'h1);
    chk(q, e, m);
  endtask

  // Noise goes into the ignored fields on purpose
  task automatic cptr(input logic [5:0] idx, input logic [2:0] w);
    logic [31:0] r;
    r = $random(seed);
    wr(3'd0, LOC_C_POINTER, {idx, r[25:7], 2'h2, w, r[1:0]});
  endtask

  task automatic tlock();
    wr(3'd0, LOC_T_LOCK, {6'd5, 26'h0});
  endtask

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    cache_test_mode = 1'b0;
    tlb_test_mode = 1'b0;
    repeat (5) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    cache_test_mode = 1'b1;
    cptr(6'd0, 3'd0);
    for (int i = 0; i < 64; i++) begin
      d = $random(seed);
      d[6:0] = {2'h2, 1'b1, d[3:1], 1'b0};
      ctag[i] = d;
      wr(3'd6, LOC_C_TAG, d);
    end
    cptr(6'd0, 3'd0);
    for (int i = 0; i < 64; i++) begin
      d = ctag[i];
      rdc(3'd6, LOC_C_TAG, {d[31:7], 2'b10, d[4:1], 1'b0}, 32'hffff_fffe);
    end
    for (int w = 0; w < 8; w++) begin
      cptr(6'd0, w[2:0]);
      for (int i = 0; i < 64; i++) begin
        cdat[w * 64 + i] = $random(seed);
        wr(3'd6, LOC_C_DATA, cdat[w * 64 + i]);
      end
    end
    for (int w = 0; w < 8; w++) begin
      cptr(6'd0, w[2:0]);
      for (int i = 0; i < 64; i++) begin
        rdc(3'd6, LOC_C_DATA, cdat[w * 64 + i], 32'hffff_ffff);
      end
    end
    wr(3'd0, LOC_C_MATCH, {ctag[11][31:7], 2'h2, 3'd3, 2'h0});
    rdc(3'd0, LOC_C_MATCH, {2'b01, cdat[3 * 64 + 11][29:0]}, 32'hffff_ffff);
    wr(3'd0, LOC_C_MATCH, {~ctag[11][31], ctag[11][30:7], 2'h2, 3'd3, 2'h0});
    rdc(3'd0, LOC_C_MATCH, 32'h8000_0000, 32'hc000_0000);
    wr(3'd0, LOC_C_INV_VA, {ctag[11][31:7], 2'h2, 5'h1f});
    wr(3'd0, LOC_C_MATCH, {ctag[11][31:7], 2'h2, 3'd3, 2'h0});
    rdc(3'd0, LOC_C_MATCH, 32'h8000_0000, 32'hc000_0000);
    wr(3'd0, LOC_C_DIRTY_ALL, 32'h0);
    d = ctag[12];
    d[3:2] = 2'b11;
    cptr(6'd12, 3'd0);
    rdc(3'd0, LOC_C_TAG, {d[31:7], 2'b10, d[4:1], 1'b0}, 32'hffff_fffe);
    wr(3'd0, LOC_C_INV_ALL, 32'h0);
    d[4] = 1'b0;
    cptr(6'd12, 3'd0);
    rdc(3'd0, LOC_C_TAG, {d[31:7], 2'b10, d[4:1], 1'b0}, 32'hffff_fffe);
    rdc(3'd0, LOC_C_INV_ALL, 32'h0, 32'hffff_ffff);
    rdc(3'd0, 6'h20, 32'h0, 32'hffff_ffff);
    cache_test_mode = 1'b0;
    tlb_test_mode = 1'b1;
    rdc(3'd0, LOC_T_DOMAIN, DOMAIN_RESET, 32'hffff_ffff);
    d = $random(seed);
    wr(3'd0, LOC_T_DOMAIN, d);
    rdc(3'd0, LOC_T_DOMAIN, d, 32'hffff_ffff);
    d = $random(seed);
    d[31:26] = 6'd7;
    wr(3'd0, LOC_T_LOCK, d);
    rdc(3'd0, LOC_T_LOCK, d & T_LOCK_MASK, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) begin
      tt = $random(seed);
      tt[9:5] = {tc[i], 1'b1};
      ts = $random(seed);
      ts[9:6] = sc[i];
      tlock();
      wr(3'd0, LOC_T_TAG, tt);
      wr(3'd0, LOC_T_SECOND, ts);
      tlock();
      rdc(3'd0, LOC_T_TAG, {tt[31:10], (i == 0) ? 4'h0 : tc[i], tt[5:4], 4'h0}, '1);
      rdc(3'd0, LOC_T_SECOND, {ts[31:10], (i == 0) ? 4'h1 : sc[i], 6'h0}, '1);
    end
    tf = $random(seed);
    tf[3:0] = 4'h4;
    tlock();
    wr(3'd0, LOC_T_FIRST, tf);
    tlock();
    rdc(3'd0, LOC_T_FIRST, {10'h0, tf[21:0]}, 32'hffff_ffff);
    tlock();
    rdc(3'd0, LOC_T_COMBINED, {10'h0, tf[21:0]}, 32'hffff_ffff);
    rdc(3'd0, LOC_T_COMBINED, {ts[31:10], 4'h1, 6'h0}, 32'hffff_ffff);
    wr(3'd0, LOC_T_MATCH, {tt[31:10], 10'h3ff});
    rdc(3'd0, LOC_T_MATCH, {10'h0, tf[21:0]}, 32'h007f_ffff);
    wr(3'd0, LOC_T_MATCH, {~tt[31], tt[30:10], 10'h0});
    rdc(3'd0, LOC_T_MATCH, 32'h0040_0000, 32'hffff_ffff);
    wr(3'd0, LOC_T_INV_ALL, 32'h0);
    wr(3'd0, LOC_T_MATCH, {tt[31:10], 10'h0});
    rdc(3'd0, LOC_T_MATCH, 32'h0040_0000, 32'hffff_ffff);
    tlock();
    wr(3'd0, LOC_T_TAG, tt);
    wr(3'd0, LOC_T_INV_VA, {tt[31:10], 10'h0});
    wr(3'd0, LOC_T_MATCH, {tt[31:10], 10'h0});
    rdc(3'd0, LOC_T_MATCH, 32'h0040_0000, 32'hffff_ffff);
    tf = $random(seed);
    ts = $random(seed);
    ts[9:6] = 4'hf;
    tlock();
    wr(3'd1, LOC_T_COMBINED, tf);
    wr(3'd1, LOC_T_COMBINED, ts);
    tlock();
    rdc(3'd0, LOC_T_FIRST, {10'h0, tf[21:0]}, 32'hffff_ffff);
    rdc(3'd0, LOC_T_SECOND, {ts[31:10], 4'hf, 6'h0}, 32'hffff_ffff);
    tlb_test_mode = 1'b0;
    rdc(3'd0, LOC_C_TAG, 32'h0, 32'hffff_ffff);
    tally_and_finish();
  end
endmodule
`default_nettype wire
